// *** hw/aie_top.sv ***
`timescale 1ns/1ps
// Operation
// R01: Transmit-early flag sets on a packet moved to the FIFO while enabled.
// R02: Receive-early flag sets when a packet fills its first descriptor while enabled.
// R03: Every status flag latches high until software writes one to it.
// R04: Link-change flag sets whenever link status changes.
// R05: Transmit-deferred flag sets on a transmit-deferred event.
// R06: Pause flag sets on a received pause frame while pause is enabled.
// R07: Normal summary flag sets when any added normal event occurs.
// R08: Abnormal summary flag sets when any added abnormal event occurs.
// R09: Status bits 14..0 are the primary status flags under either address.
// R10: Added enables at 31,30,29,28,26 are read/write and reset to zero.
// R11: Normal summary enable merges early events into the primary normal summary.
// R12: Abnormal summary enable merges pause, deferred, link events into abnormal summary.
// R13: Enable bits 14..0 are the primary enables under either address.
// R14: Command upper half is loaded from the serial EEPROM.
// R15: D3cold support defaults to one and drives the capability bit.
// R16: Aux current field is read-only, defaults to 010b.
// R17: An enabled wake pin carries a 50 ms pulse, negative when polarity is one.
// R18: Wake pin is an output only when its enable bit is one.
// R19: A hardware set beats a simultaneous software clear.
module aie_top #(
  parameter int WAKE_PULSE_CYCLES = aie_pkg::WAKE_PULSE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Events from the MAC
  input wire logic tx_early_evt,
  input wire logic rx_early_evt,
  input wire logic link_change_evt,
  input wire logic tx_deferred_evt,
  input wire logic pause_rcvd_evt,
  input wire logic pause_fn_en,
  input wire logic [14:0] prim_evt,
  // EEPROM recall
  input wire logic ee_load,
  input wire logic [15:0] ee_word,
  // Wake pulse
  input wire logic wake_evt,
  input wire logic wake_pin_i,
  output logic wake_pin_o,
  output logic wake_pin_oe,
  // Interrupt and power management
  output logic irq,
  output logic norm_summary,
  output logic abn_summary,
  output logic pm_d3cold_support,
  output logic [2:0] pm_aux_current
);

  // ==========================================================================
  // Address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  wire wr_prim_stat = reg_wr && hit(reg_addr, aie_pkg::OFS_PRIM_STATUS);
  wire wr_prim_ena = reg_wr && hit(reg_addr, aie_pkg::OFS_PRIM_ENABLE);
  wire wr_add_stat = reg_wr && hit(reg_addr, aie_pkg::OFS_ADD_STATUS);
  wire wr_add_ena = reg_wr && hit(reg_addr, aie_pkg::OFS_ADD_ENABLE);
  wire wr_cmd = reg_wr && hit(reg_addr, aie_pkg::OFS_CMD_UPPER);
  wire wr_clear = reg_wr && hit(reg_addr, aie_pkg::OFS_STAT_CLEAR);

  // ==========================================================================
  // Status flags
  logic [31:0] stat_r;
  logic [31:0] stat_nxt;
  logic [31:0] ena_r;
  logic [31:0] ena_nxt;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;

  wire tx_early_set = tx_early_evt && ena_r[aie_pkg::B_TX_EARLY]; // R01
  wire rx_early_set = rx_early_evt && ena_r[aie_pkg::B_RX_EARLY]; // R02
  wire pause_set = pause_rcvd_evt && pause_fn_en; // R06
  wire norm_evt = tx_early_set || rx_early_set; // R07
  wire abn_evt = link_change_evt || tx_deferred_evt || pause_set; // R08

  always_comb begin
    set_vec = '0;
    set_vec[aie_pkg::B_TX_EARLY] = tx_early_set; // R01
    set_vec[aie_pkg::B_RX_EARLY] = rx_early_set; // R02
    set_vec[aie_pkg::B_LINK_CHG] = link_change_evt; // R04
    set_vec[aie_pkg::B_TX_DEFER] = tx_deferred_evt; // R05
    set_vec[aie_pkg::B_PAUSE] = pause_set; // R06
    set_vec[aie_pkg::B_NORM_SUM] = norm_evt; // R07
    set_vec[aie_pkg::B_ABN_SUM] = abn_evt; // R08
    set_vec[14:0] = prim_evt;
  end

  // Primary alias clears only the shared low flags
  assign clr_vec = ((wr_add_stat || wr_clear) ? reg_wdata : 32'h0000_0000)
                 | (wr_prim_stat ? {17'h00000, reg_wdata[14:0]} : 32'h0000_0000); // R09
  assign stat_nxt = ((stat_r & ~clr_vec) | set_vec) & aie_pkg::IMPL_MASK; // R03 R19

  // ==========================================================================
  // Enables
  assign ena_nxt = wr_add_ena ? (reg_wdata & aie_pkg::IMPL_MASK)
                 : (wr_prim_ena ? {ena_r[31:15], reg_wdata[14:0]} : ena_r); // R10 R13

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      stat_r <= aie_pkg::STAT_RST;
      ena_r <= aie_pkg::ENA_RST; // R10
    end else begin
      stat_r <= stat_nxt;
      ena_r <= ena_nxt;
    end
  end

  // ==========================================================================
  // Interrupt summaries
  wire [14:0] prim_act = stat_r[14:0] & ena_r[14:0];
  wire add_norm_act = (stat_r[aie_pkg::B_TX_EARLY] && ena_r[aie_pkg::B_TX_EARLY])
                   || (stat_r[aie_pkg::B_RX_EARLY] && ena_r[aie_pkg::B_RX_EARLY]);
  wire add_abn_act = (stat_r[aie_pkg::B_LINK_CHG] && ena_r[aie_pkg::B_LINK_CHG])
                  || (stat_r[aie_pkg::B_TX_DEFER] && ena_r[aie_pkg::B_TX_DEFER])
                  || (stat_r[aie_pkg::B_PAUSE] && ena_r[aie_pkg::B_PAUSE]);

  assign norm_summary = (|(prim_act & aie_pkg::PRIM_NORM_MASK))
                     || (ena_r[aie_pkg::B_NORM_SUM] && add_norm_act); // R11
  assign abn_summary = (|(prim_act & ~aie_pkg::PRIM_NORM_MASK))
                    || (ena_r[aie_pkg::B_ABN_SUM] && add_abn_act); // R12
  assign irq = norm_summary || abn_summary;

  // ==========================================================================
  // Command register upper half
  logic d3cold_r;
  logic [2:0] aux_r;
  logic wake_pol_r;
  logic wake_en_r;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      d3cold_r <= aie_pkg::RST_D3COLD; // R15
      aux_r <= aie_pkg::RST_AUX; // R16
      wake_pol_r <= aie_pkg::RST_WAKE_POL;
      wake_en_r <= aie_pkg::RST_WAKE_EN;
    end else if (ee_load) begin
      // EEPROM recall wins over a software write in the same cycle
      d3cold_r <= ee_word[aie_pkg::B_D3COLD-16]; // R14
      aux_r <= ee_word[aie_pkg::B_AUX_HI-16:aie_pkg::B_AUX_LO-16]; // R14
      wake_pol_r <= ee_word[aie_pkg::B_WAKE_POL-16]; // R14
      wake_en_r <= ee_word[aie_pkg::B_WAKE_EN-16]; // R14
    end else if (wr_cmd) begin
      d3cold_r <= reg_wdata[aie_pkg::B_D3COLD];
      wake_pol_r <= reg_wdata[aie_pkg::B_WAKE_POL];
      wake_en_r <= reg_wdata[aie_pkg::B_WAKE_EN];
    end
  end

  assign pm_d3cold_support = d3cold_r; // R15
  assign pm_aux_current = aux_r; // R16

  // ==========================================================================
  // Wake pulse generator
  aie_wake_if wk ();

  assign wk.trigger = wake_evt;
  assign wk.polarity = wake_pol_r; // R17
  assign wk.pin_en = wake_en_r; // R18

  aie_wake_pulse #(
    .PULSE_CYCLES(WAKE_PULSE_CYCLES)
  ) u_wake (
    .mclk(mclk),
    .nrst(nrst),
    .ctl(wk.gen),
    .wake_pin_i(wake_pin_i),
    .wake_pin_o(wake_pin_o),
    .wake_pin_oe(wake_pin_oe)
  );

  // ==========================================================================
  // Read path
  wire [31:0] cmd_view = {d3cold_r, aux_r, wake_pol_r, wake_en_r, 26'h0000000};
  wire [31:0] prim_stat_view = {15'h0000, norm_summary, abn_summary, stat_r[14:0]};
  wire [31:0] prim_ena_view = {17'h00000, ena_r[14:0]};
  wire [31:0] pin_view = {30'h00000000, wk.busy, wk.pin_level};
  logic [31:0] rd_mux;
  logic [31:0] rdata_r;

  always_comb begin
    unique case (reg_addr)
      aie_pkg::OFS_PRIM_STATUS: rd_mux = prim_stat_view; // R09
      aie_pkg::OFS_PRIM_ENABLE: rd_mux = prim_ena_view; // R13
      aie_pkg::OFS_ADD_STATUS: rd_mux = stat_r;
      aie_pkg::OFS_ADD_ENABLE: rd_mux = ena_r;
      aie_pkg::OFS_CMD_UPPER: rd_mux = cmd_view;
      aie_pkg::OFS_PIN_STATE: rd_mux = pin_view;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_r;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_tx_early_set: assert property (tx_early_evt && ena_r[31] |=> stat_r[31]) // R01
    else $error("tx early flag not set");
  a_tx_early_gate: assert property (!stat_r[31] && !ena_r[31] |=> !stat_r[31]) // R01
    else $error("tx early flag set while disabled");
  a_rx_early_set: assert property (rx_early_evt && ena_r[30] |=> stat_r[30]) // R02
    else $error("rx early flag not set");
  a_flag_hold: assert property (stat_r[29] && !clr_vec[29] |=> stat_r[29]) // R03
    else $error("flag dropped without clear");
  a_flag_clear: assert property (stat_r[26] && wr_add_stat && reg_wdata[26] && !pause_set |=> !stat_r[26]) // R03
    else $error("flag not cleared by one-write");
  a_rx_early_gate: assert property (!stat_r[30] && !ena_r[30] |=> !stat_r[30]) // R02
    else $error("rx early flag set while disabled");
  a_pause_set: assert property (pause_set |=> stat_r[26]) // R06
    else $error("pause flag not set");
  a_link_set: assert property (link_change_evt |=> stat_r[29] && stat_r[15]) // R04
    else $error("link change flag not set");
  a_defer_set: assert property (tx_deferred_evt |=> stat_r[28]) // R05
    else $error("deferred flag not set");
  a_pause_gate: assert property (!stat_r[26] && pause_rcvd_evt && !pause_fn_en |=> !stat_r[26]) // R06
    else $error("pause flag set while pause disabled");
  a_norm_sum: assert property (rx_early_set |=> stat_r[16]) // R07
    else $error("normal summary flag not set");
  a_abn_sum: assert property (pause_set |=> stat_r[15] && stat_r[26]) // R08
    else $error("abnormal summary flag not set");
  a_status_alias: assert property (reg_rd && reg_addr == 8'h28 |=> reg_rdata[14:0] == $past(stat_r[14:0])) // R09
    else $error("primary status alias mismatch");
  a_alias_clear: assert property (wr_prim_stat && reg_wdata[3] && !prim_evt[3] |=> !stat_r[3]) // R09
    else $error("alias one-write did not clear");
  a_enable_write: assert property (wr_add_ena |=> ena_r == ($past(reg_wdata) & 32'hf401_ffff)) // R10
    else $error("enable register write lost");
  a_norm_merge: assert property (ena_r[16] && ena_r[31] && stat_r[31] |-> norm_summary && irq) // R11
    else $error("early event not merged into normal summary");
  a_abn_merge: assert property (ena_r[15] && ena_r[28] && stat_r[28] |-> abn_summary && irq) // R12
    else $error("deferred event not merged into abnormal summary");
  a_no_merge: assert property (ena_r[14:0] == 15'h0000 && !ena_r[15] && !ena_r[16] |-> !irq) // R11
    else $error("interrupt without enabled source");
  a_enable_alias: assert property (wr_prim_ena |=> ena_r[14:0] == $past(reg_wdata[14:0])) // R13
    else $error("primary enable alias write lost");
  a_eeprom_load: assert property (ee_load |=> {pm_d3cold_support, pm_aux_current} == $past(ee_word[15:12])) // R14
    else $error("eeprom recall not applied");
  a_d3cold_write: assert property (wr_cmd && !ee_load |=> pm_d3cold_support == $past(reg_wdata[31])) // R15
    else $error("d3cold bit not reflected");
  a_aux_readonly: assert property (wr_cmd && !ee_load |=> $stable(pm_aux_current)) // R16
    else $error("aux current changed by software");
  a_pin_dir: assert property (wr_cmd && !ee_load |=> ##1 wake_pin_oe == $past(reg_wdata[26], 2)) // R18
    else $error("wake pin direction wrong");
  a_set_wins: assert property (tx_deferred_evt && wr_clear && reg_wdata[28] |=> stat_r[28]) // R19
    else $error("clear beat a simultaneous set");

  c_irq_norm: cover property (norm_evt ##1 irq);
  c_irq_abn: cover property (link_change_evt ##1 abn_summary ##[1:20] !abn_summary);
  c_set_clear: cover property (tx_deferred_evt && wr_clear && reg_wdata[28]);
  c_wake_pulse: cover property (wake_en_r && wake_evt);

endmodule // aie_top

// *** hw/aie_wake_pulse.sv ***
`timescale 1ns/1ps
module aie_wake_pulse #(
  parameter int PULSE_CYCLES = aie_pkg::WAKE_PULSE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Control side
  aie_wake_if.gen ctl,
  // Wake pin
  input wire logic wake_pin_i,
  output logic wake_pin_o,
  output logic wake_pin_oe
);
  localparam int CW = $clog2(PULSE_CYCLES + 1);

  // ==========================================================================
  // Pulse timer
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic active_r;
  logic pin_o_r;
  logic sync1_r;
  logic sync2_r;
  wire start = ctl.trigger && ctl.pin_en && !active_r;
  wire last = active_r && (cnt_r == CW'(1));

  assign cnt_nxt = start ? CW'(PULSE_CYCLES) : (active_r ? cnt_r - CW'(1) : cnt_r);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt_r <= '0;
      active_r <= 1'b0;
      pin_o_r <= 1'b0;
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      active_r <= start || (active_r && !last);
      // Idle level is the polarity bit, the pulse is its inverse
      pin_o_r <= (start || (active_r && !last)) ? !ctl.polarity : ctl.polarity; // R17
      sync1_r <= wake_pin_i;
      sync2_r <= sync1_r;
    end
  end

  assign wake_pin_o = pin_o_r;
  assign wake_pin_oe = ctl.pin_en; // R18
  assign ctl.busy = active_r;
  assign ctl.pin_level = sync2_r;

  a_pulse_start: assert property (@(posedge mclk) disable iff (!nrst)
    start |=> wake_pin_o == !$past(ctl.polarity)) else $error("wake pulse did not start"); // R17
  a_pulse_end: assert property (@(posedge mclk) disable iff (!nrst)
    last |=> !active_r && wake_pin_o == $past(ctl.polarity)) else $error("wake pulse did not end"); // R17
  a_pin_input: assert property (@(posedge mclk) disable iff (!nrst)
    !ctl.pin_en && !active_r |=> !active_r) else $error("wake pulse started while pin disabled"); // R18
  c_pulse_done: cover property (@(posedge mclk) disable iff (!nrst) last);
endmodule // aie_wake_pulse

// *** include/aie_pkg.sv ***
package aie_pkg;
  // ==========================================================================
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_PRIM_STATUS = 8'h28;
  localparam logic [7:0] OFS_PRIM_ENABLE = 8'h38;
  localparam logic [7:0] OFS_ADD_STATUS = 8'h80;
  localparam logic [7:0] OFS_ADD_ENABLE = 8'h84;
  localparam logic [7:0] OFS_CMD_UPPER = 8'h88;
  localparam logic [7:0] OFS_STAT_CLEAR = 8'h90;
  localparam logic [7:0] OFS_PIN_STATE = 8'h94;

  // ==========================================================================
  // Added status / enable bit positions
  localparam int B_TX_EARLY = 31;
  localparam int B_RX_EARLY = 30;
  localparam int B_LINK_CHG = 29;
  localparam int B_TX_DEFER = 28;
  localparam int B_PAUSE = 26;
  localparam int B_NORM_SUM = 16;
  localparam int B_ABN_SUM = 15;
  localparam int PRIM_W = 15;
  localparam logic [31:0] IMPL_MASK = 32'hf401_ffff;
  localparam logic [31:0] STAT_RST = 32'h0000_0000;
  localparam logic [31:0] ENA_RST = 32'h0000_0000;
  // Primary flags counted as normal events; the rest are abnormal
  localparam logic [14:0] PRIM_NORM_MASK = 15'h0045;

  // ==========================================================================
  // Command register upper half
  localparam int B_D3COLD = 31;
  localparam int B_AUX_HI = 30;
  localparam int B_AUX_LO = 28;
  localparam int B_WAKE_POL = 27;
  localparam int B_WAKE_EN = 26;
  localparam logic RST_D3COLD = 1'b1;
  localparam logic [2:0] RST_AUX = 3'h2;
  localparam logic RST_WAKE_POL = 1'b0;
  localparam logic RST_WAKE_EN = 1'b0;

  // ==========================================================================
  // Timing
  localparam int CLK_KHZ = 25000;
  localparam int WAKE_PULSE_MS = 50;
  localparam int WAKE_PULSE_CYC = WAKE_PULSE_MS * CLK_KHZ;
endpackage

// *** include/aie_wake_if.sv ***
`timescale 1ns/1ps
interface aie_wake_if;
  logic trigger;
  logic polarity;
  logic pin_en;
  logic busy;
  logic pin_level;
  modport ctrl (output trigger, output polarity, output pin_en, input busy, input pin_level);
  modport gen (input trigger, input polarity, input pin_en, output busy, output pin_level);
endinterface // aie_wake_if

// *** testbench/aie_host_model.sv ***
`timescale 1ns/1ps
// ============================================================================
// Host driver model: single-cycle strobes, read data taken in the next cycle
module aie_host_model (
  // Clock
  input wire logic mclk,
  // Register port
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule // aie_host_model

// *** testbench/test_added_interrupt_status_enable.sv ***
`timescale 1ns/1ps
module test_added_interrupt_status_enable;
  localparam int PULSE = 20;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, pause_fn_en = 1'b0, ee_load = 1'b0;
  logic [5:0] evt = 6'h00;
  logic [14:0] prim_evt = 15'h0000;
  logic [15:0] ee_word = 16'h0000;
  logic wake_pin_o, wake_pin_oe, irq, norm_summary, abn_summary, pm_d3cold_support;
  logic [2:0] pm_aux_current;
  int n_mismatch = 0;
  int check_count = 0;

  always #20 mclk = ~mclk;

  aie_host_model i_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  aie_top #(.WAKE_PULSE_CYCLES(PULSE)) i_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_early_evt(evt[0]), .rx_early_evt(evt[1]), .link_change_evt(evt[2]), .tx_deferred_evt(evt[3]),
    .pause_rcvd_evt(evt[4]), .pause_fn_en(pause_fn_en), .prim_evt(prim_evt), .ee_load(ee_load),
    .ee_word(ee_word), .wake_evt(evt[5]), .wake_pin_i(1'b1), .wake_pin_o(wake_pin_o),
    .wake_pin_oe(wake_pin_oe), .irq(irq), .norm_summary(norm_summary), .abn_summary(abn_summary),
    .pm_d3cold_support(pm_d3cold_support), .pm_aux_current(pm_aux_current));

  // ==========================================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    i_host.rd(a, d);
    chk(what, exp, d);
  endtask

  task automatic pulse(input int b);
    @(posedge mclk);
    evt[b] <= 1'b1;
    @(posedge mclk);
    evt[b] <= 1'b0;
    #1;
  endtask

  task automatic wrap_up;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rd_chk("status", 8'h80, 32'h0000_0000);
    rd_chk("enable", 8'h84, 32'h0000_0000);
    rd_chk("command", 8'h88, 32'ha000_0000);
    chk("d3cold", 32'h1, {31'h0, pm_d3cold_support});
    chk("aux", 32'h2, {29'h0, pm_aux_current});
  endtask

  task automatic t_enables;
    i_host.wr(8'h84, 32'hffff_ffff);
    rd_chk("enable all", 8'h84, 32'hf401_ffff);
    i_host.wr(8'h38, 32'h0000_1234);
    i_host.rd(8'h84, d);
    chk("enable alias", 32'h1234, {17'h0, d[14:0]});
    i_host.wr(8'h84, 32'h0000_0000);
  endtask

  task automatic t_early;
    pulse(0);
    rd_chk("tx early off", 8'h80, 32'h0000_0000);
    i_host.wr(8'h84, 32'hc000_0000);
    pulse(0);
    rd_chk("tx early", 8'h80, 32'h8001_0000);
    pulse(1);
    rd_chk("rx early", 8'h80, 32'hc001_0000);
    i_host.wr(8'h80, 32'hc001_0000);
    rd_chk("early cleared", 8'h80, 32'h0000_0000);
  endtask

  task automatic t_abnormal;
    pulse(2);
    rd_chk("link", 8'h80, 32'h2000_8000);
    pulse(3);
    rd_chk("deferred", 8'h80, 32'h3000_8000);
    pulse(4);
    rd_chk("pause off", 8'h80, 32'h3000_8000);
    pause_fn_en <= 1'b1;
    pulse(4);
    rd_chk("pause", 8'h80, 32'h3400_8000);
    i_host.wr(8'h90, 32'h3400_8000);
    rd_chk("abn cleared", 8'h80, 32'h0000_0000);
  endtask

  task automatic t_summary;
    i_host.wr(8'h84, 32'h2000_8000);
    chk("irq idle", 32'h0, {31'h0, irq});
    pulse(2);
    chk("abn summary", 32'h3, {30'h0, abn_summary, irq});
    i_host.wr(8'h80, 32'h2000_8000);
    i_host.wr(8'h84, 32'h8001_0000);
    #1;
    chk("irq cleared", 32'h0, {31'h0, irq});
    pulse(0);
    chk("norm summary", 32'h3, {30'h0, norm_summary, irq});
    i_host.wr(8'h80, 32'h8001_0000);
    i_host.wr(8'h84, 32'h0000_0000);
  endtask

  task automatic t_alias;
    @(posedge mclk);
    prim_evt <= 15'h0008;
    @(posedge mclk);
    prim_evt <= 15'h0000;
    i_host.rd(8'h80, d);
    chk("alias added", 32'h8, {17'h0, d[14:0]});
    i_host.rd(8'h28, d);
    chk("alias primary", 32'h8, {17'h0, d[14:0]});
    i_host.wr(8'h28, 32'h0000_0008);
    i_host.rd(8'h80, d);
    chk("alias clear", 32'h0, {17'h0, d[14:0]});
  endtask

  task automatic t_race;
    fork
      i_host.wr(8'h80, 32'h2000_8000);
      pulse(2);
    join
    i_host.rd(8'h80, d);
    chk("set beats clear", 32'h1, {31'h0, d[29]});
    i_host.wr(8'h80, 32'h2000_8000);
  endtask

  task automatic t_eeprom;
    @(posedge mclk);
    ee_word <= 16'h5c00;
    ee_load <= 1'b1;
    @(posedge mclk);
    ee_load <= 1'b0;
    rd_chk("ee command", 8'h88, 32'h5c00_0000);
    chk("ee pm", 32'h5, {28'h0, pm_d3cold_support, pm_aux_current});
    chk("pin drive", 32'h3, {30'h0, wake_pin_oe, wake_pin_o});
    i_host.wr(8'h88, 32'hffff_ffff);
    rd_chk("aux ro", 8'h88, 32'hdc00_0000);
  endtask

  task automatic wake_len(input logic pol);
    int n;
    pulse(5);
    n = 0;
    while (wake_pin_o === !pol && n < 100) begin
      n++;
      @(posedge mclk);
      #1;
    end
    chk("pulse length", PULSE, n);
    chk("pin idle", {31'h0, pol}, {31'h0, wake_pin_o});
  endtask

  task automatic t_wake;
    wake_len(1'b1);
    i_host.wr(8'h88, 32'h8400_0000);
    wake_len(1'b0);
    i_host.wr(8'h88, 32'h8000_0000);
    pulse(5);
    chk("pin off", 32'h0, {31'h0, wake_pin_oe});
    rd_chk("pin state", 8'h94, 32'h0000_0001);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_enables();
    t_early();
    t_abnormal();
    t_summary();
    t_alias();
    t_race();
    t_eeprom();
    t_wake();
    wrap_up();
  end

  initial begin
    repeat (3000) @(posedge mclk);
    n_mismatch++;
    wrap_up();
  end
endmodule // test_added_interrupt_status_enable
